// ---- hw/drtp_defs.svh ----
// Constants for the ramp time and torque limit parameter register bank.
`ifndef DRTP_DEFS_SVH
`define DRTP_DEFS_SVH

// ==========================================================
// Register indices on the communications port
`define DRTP_IDX_ACCEL        2'h0
`define DRTP_IDX_DECEL        2'h1
`define DRTP_IDX_DRIVE_TQ     2'h2
`define DRTP_IDX_BRAKE_TQ     2'h3

// ==========================================================
// Permitted ranges, in steps of each register's resolution
`define DRTP_TIME_MIN         16'h0000
`define DRTP_TIME_MAX         16'h8CA0
`define DRTP_TQ_MIN           16'h07D0
`define DRTP_TQ_MAX           16'h3A98
`define DRTP_TQ_SPECIAL       16'h03E7

// ==========================================================
// Time truncation: from this value on only whole seconds stay
`define DRTP_TRUNC_MIN        16'h03E8
`define DRTP_TRUNC_STEP       16'h000A

// ==========================================================
// Reset values of the four settings
`define DRTP_RST_ACCEL        16'h0064
`define DRTP_RST_DECEL        16'h0064
`define DRTP_RST_DRIVE_TQ     16'h03E7
`define DRTP_RST_BRAKE_TQ     16'h03E7

`endif

// ---- hw/drtp_pkg.sv ----
// Types shared by the ramp time and torque limit parameter register bank.
package drtp_pkg;

  // ==========================================================
  // Register selector
  typedef enum logic [1:0] {
    DRTP_SEL_ACCEL    = 2'b00,
    DRTP_SEL_DECEL    = 2'b01,
    DRTP_SEL_DRIVE_TQ = 2'b10,
    DRTP_SEL_BRAKE_TQ = 2'b11
  } drtp_sel_t;

  // ==========================================================
  // Write request: register selector and value
  typedef struct packed {
    drtp_sel_t   sel;
    logic [15:0] data;
  } drtp_req_t;

  // ==========================================================
  // Write answer towards the communications side
  typedef struct packed {
    logic ack;
    logic err;
  } drtp_resp_t;

endpackage

// ---- hw/drtp_trunc.sv ----
// Drops the tenths of a ramp time once the time reaches four digits.
`timescale 1ns/10ps
`default_nettype none
`include "drtp_defs.svh"

module drtp_trunc #(
  parameter int DATA_W = 16
) (
  // Value as written
  input  wire logic [DATA_W-1:0] in_val,
  // Value as stored
  output logic      [DATA_W-1:0] out_val
);

  logic [DATA_W-1:0] rem;

  // The truncation constants need at least sixteen bits.
  generate
    if (DATA_W < 16) begin : g_bad_width
      $error("drtp_trunc needs a data width of at least 16");
    end
  endgenerate

  // Truncate towards zero, never round: 123.4 s becomes 123.0 s.
  always_comb begin
    rem = in_val % DATA_W'(`DRTP_TRUNC_STEP);
    if (in_val >= DATA_W'(`DRTP_TRUNC_MIN)) begin
      out_val = in_val - rem;
    end else begin
      out_val = in_val;
    end
  end

endmodule
`default_nettype wire

// ---- hw/drtp_regs.sv ----
// Ramp time and torque limit parameter registers with range check.
//
// Function
// - Ramp time registers take 0 to 3600.0 s in 0.1 s steps.
// - Torque limit registers take 20.00 to 150.00 percent, or 999.
// - Out-of-range writes are refused and answered with an error.
// - Accepted ramp time writes update the internal first ramp times.
// - Accepted torque limit writes update the internal torque limits.
// - Keypad changes of the settings are reflected in register reads.
// - Ramp time writes of 100.0 s and more lose their tenths, truncated to whole seconds.
// - All four registers are readable and writable over the link.
`timescale 1ns/10ps
`default_nettype none
`include "drtp_defs.svh"

module drtp_regs #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // Communications write port
  input  wire logic                   comm_wr_en,
  input  wire drtp_pkg::drtp_req_t    comm_wr,
  output drtp_pkg::drtp_resp_t        comm_wr_resp,
  // Communications read port
  input  wire logic                   comm_rd_en,
  input  wire drtp_pkg::drtp_sel_t    comm_rd_sel,
  output logic                        comm_rd_valid,
  output logic        [DATA_W-1:0]    comm_rd_data,
  // Keypad edits of the internal settings
  input  wire logic                   kp_wr_en,
  input  wire drtp_pkg::drtp_req_t    kp_wr,
  // Internal settings used by the drive
  output logic        [DATA_W-1:0]    internal_accel_time_1,
  output logic        [DATA_W-1:0]    internal_decel_time_1,
  output logic        [DATA_W-1:0]    internal_drive_torque_limit,
  output logic        [DATA_W-1:0]    internal_brake_torque_limit
);
  import drtp_pkg::*;

  // ==========================================================
  // Elaboration check
  generate
    if (DATA_W != 16) begin : g_bad_width
      $error("drtp_regs serves a data width of 16 only");
    end
  endgenerate

  // ==========================================================
  // Declarations
  localparam int NREG = 4;

  logic [DATA_W-1:0] param_ff     [NREG];
  logic [DATA_W-1:0] nxt_param    [NREG];
  logic [DATA_W-1:0] trunc_val;
  logic [DATA_W-1:0] store_val;
  logic              is_time;
  logic              in_range;
  logic              accept;
  drtp_resp_t        resp_ff;
  drtp_resp_t        nxt_resp;
  logic              rd_valid_ff;
  logic              nxt_rd_valid;
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] nxt_rd_data;

  // Reset values per register, constants so the reset branch stays constant.
  localparam logic [DATA_W-1:0] RST_VAL [NREG] = '{
    `DRTP_RST_ACCEL,
    `DRTP_RST_DECEL,
    `DRTP_RST_DRIVE_TQ,
    `DRTP_RST_BRAKE_TQ
  };

  // ==========================================================
  // Write value path
  // The truncator works on every ramp time written over the link.
  drtp_trunc #(
    .DATA_W (DATA_W)
  ) u_trunc (
    .in_val  (comm_wr.data),
    .out_val (trunc_val)
  );

  // Range check and choice of the value to store.
  always_comb begin
    is_time = (comm_wr.sel == DRTP_SEL_ACCEL) || (comm_wr.sel == DRTP_SEL_DECEL);
    if (is_time) begin
      in_range = (comm_wr.data <= `DRTP_TIME_MAX);
    end else begin
      in_range = ((comm_wr.data >= `DRTP_TQ_MIN) && (comm_wr.data <= `DRTP_TQ_MAX))
              || (comm_wr.data == `DRTP_TQ_SPECIAL);
    end
    accept    = comm_wr_en && in_range;
    store_val = is_time ? trunc_val : comm_wr.data;
  end

  // ==========================================================
  // Parameter storage, one register per setting
  // A keypad edit in the same cycle as a link write to the same
  // register wins, since the operator stands at the machine.
  generate
    for (genvar gi = 0; gi < NREG; gi++) begin : g_param
      always_comb begin
        nxt_param[gi] = param_ff[gi];
        if (kp_wr_en && (kp_wr.sel == drtp_sel_t'(gi))) begin
          nxt_param[gi] = kp_wr.data;
        end else if (accept && (comm_wr.sel == drtp_sel_t'(gi))) begin
          nxt_param[gi] = store_val;
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          param_ff[gi] <= RST_VAL[gi];
        end else begin
          param_ff[gi] <= nxt_param[gi];
        end
      end
    end
  endgenerate

  // Internal settings are the stored registers themselves.
  assign internal_accel_time_1       = param_ff[0];
  assign internal_decel_time_1       = param_ff[1];
  assign internal_drive_torque_limit = param_ff[2];
  assign internal_brake_torque_limit = param_ff[3];

  // ==========================================================
  // Answers on the communications side
  // Write answers and read data are one-cycle, registered answers.
  always_comb begin
    nxt_resp.ack = accept;
    nxt_resp.err = comm_wr_en && !in_range;
    nxt_rd_valid = comm_rd_en;
    nxt_rd_data  = rd_data_ff;
    if (comm_rd_en) begin
      nxt_rd_data = param_ff[comm_rd_sel];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_ff     <= '0;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end else begin
      resp_ff     <= nxt_resp;
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff  <= nxt_rd_data;
    end
  end

  assign comm_wr_resp  = resp_ff;
  assign comm_rd_valid = rd_valid_ff;
  assign comm_rd_data  = rd_data_ff;

  // ==========================================================
  // Assertions
  // Accepted ramp time writes never leave the time range.
  property p_time_range;
    @(posedge mclk) disable iff (!rst_n)
      (comm_wr_en && is_time && !kp_wr_en && comm_wr_resp.ack == 1'b0)
      ##1 comm_wr_resp.ack |-> ($past(comm_wr.data) <= `DRTP_TIME_MAX);
  endproperty
  a_time_range: assert property (p_time_range)
    else $error("ramp time accepted outside its range");

  // Torque writes beyond the bounds, other than 999, are refused.
  property p_tq_range;
    @(posedge mclk) disable iff (!rst_n)
      (comm_wr_en && !is_time
       && (comm_wr.data < `DRTP_TQ_MIN || comm_wr.data > `DRTP_TQ_MAX)
       && comm_wr.data != `DRTP_TQ_SPECIAL)
      |=> comm_wr_resp.err && !comm_wr_resp.ack;
  endproperty
  a_tq_range: assert property (p_tq_range)
    else $error("torque limit outside range not refused");

  // A refused write leaves the target register untouched.
  property p_reject;
    @(posedge mclk) disable iff (!rst_n)
      (comm_wr_en && !in_range && !kp_wr_en)
      |=> comm_wr_resp.err && $stable(internal_accel_time_1) && $stable(internal_decel_time_1)
          && $stable(internal_drive_torque_limit) && $stable(internal_brake_torque_limit);
  endproperty
  a_reject: assert property (p_reject)
    else $error("refused write changed a register");

  // Accepted acceleration write reaches the internal setting.
  property p_accel_upd;
    @(posedge mclk) disable iff (!rst_n)
      (accept && comm_wr.sel == DRTP_SEL_ACCEL && !kp_wr_en)
      |=> comm_wr_resp.ack && internal_accel_time_1 == $past(trunc_val);
  endproperty
  a_accel_upd: assert property (p_accel_upd)
    else $error("acceleration time not updated");

  // Accepted deceleration write reaches the internal setting.
  property p_decel_upd;
    @(posedge mclk) disable iff (!rst_n)
      (accept && comm_wr.sel == DRTP_SEL_DECEL && !kp_wr_en)
      |=> internal_decel_time_1 == $past(trunc_val);
  endproperty
  a_decel_upd: assert property (p_decel_upd)
    else $error("deceleration time not updated");

  // Accepted braking torque limit writes land in their setting, the drive limit unchanged.
  property p_tq_upd;
    @(posedge mclk) disable iff (!rst_n)
      (accept && comm_wr.sel == DRTP_SEL_BRAKE_TQ && !kp_wr_en)
      |=> internal_brake_torque_limit == $past(comm_wr.data)
          && $stable(internal_drive_torque_limit);
  endproperty
  a_tq_upd: assert property (p_tq_upd)
    else $error("braking torque limit not updated");

  // A keypad edit shows up in a read two cycles later.
  property p_kp_reflect;
    @(posedge mclk) disable iff (!rst_n)
      (kp_wr_en && kp_wr.sel == DRTP_SEL_DRIVE_TQ)
      ##1 (comm_rd_en && comm_rd_sel == DRTP_SEL_DRIVE_TQ && !kp_wr_en
           && !(comm_wr_en))
      |=> comm_rd_valid && comm_rd_data == $past(kp_wr.data, 2);
  endproperty
  a_kp_reflect: assert property (p_kp_reflect)
    else $error("keypad edit not visible on the link");

  // Long ramp times lose their tenths.
  property p_trunc;
    @(posedge mclk) disable iff (!rst_n)
      (accept && is_time && comm_wr.data >= `DRTP_TRUNC_MIN && !kp_wr_en)
      |=> param_ff[$past(comm_wr.sel)] % `DRTP_TRUNC_STEP == 16'h0000
          && param_ff[$past(comm_wr.sel)] <= $past(comm_wr.data);
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("ramp time not truncated");

  // Every read is answered the next cycle with the stored value.
  property p_read;
    @(posedge mclk) disable iff (!rst_n)
      comm_rd_en |=> comm_rd_valid
        && comm_rd_data == $past(param_ff[comm_rd_sel]);
  endproperty
  a_read: assert property (p_read)
    else $error("read answer wrong or late");

  // Torque values are stored as raw step counts, unscaled.
  property p_raw_count;
    @(posedge mclk) disable iff (!rst_n)
      (accept && comm_wr.sel == DRTP_SEL_DRIVE_TQ && !kp_wr_en)
      |=> internal_drive_torque_limit == $past(comm_wr.data)
          ##1 (!comm_wr_resp.ack || comm_wr_resp.err == 1'b0);
  endproperty
  a_raw_count: assert property (p_raw_count)
    else $error("torque value not stored as raw count");

  // Acknowledge and error never answer the same write.
  property p_resp_excl;
    @(posedge mclk) disable iff (!rst_n)
      !(comm_wr_resp.ack && comm_wr_resp.err);
  endproperty
  a_resp_excl: assert property (p_resp_excl)
    else $error("write both accepted and refused");

  // Read data holds between reads, and valid only answers a read.
  property p_rd_hold;
    @(posedge mclk) disable iff (!rst_n)
      !comm_rd_en |=> !comm_rd_valid && $stable(comm_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read answer changed without a read");

  // A keypad edit is stored as given, neither checked nor truncated.
  property p_kp_store;
    @(posedge mclk) disable iff (!rst_n)
      (kp_wr_en && kp_wr.sel == DRTP_SEL_ACCEL)
      |=> internal_accel_time_1 == $past(kp_wr.data);
  endproperty
  a_kp_store: assert property (p_kp_store)
    else $error("keypad edit not stored as given");

  // Ramp times under four digits are stored exactly as written.
  property p_short_time;
    @(posedge mclk) disable iff (!rst_n)
      (accept && comm_wr.sel == DRTP_SEL_DECEL && comm_wr.data < `DRTP_TRUNC_MIN && !kp_wr_en)
      |=> internal_decel_time_1 == $past(comm_wr.data);
  endproperty
  a_short_time: assert property (p_short_time)
    else $error("short ramp time altered");

  // ==========================================================
  // Coverage of the main scenarios
  c_special: cover property (@(posedge mclk) disable iff (!rst_n)
    accept && comm_wr.data == `DRTP_TQ_SPECIAL);
  c_trunc: cover property (@(posedge mclk) disable iff (!rst_n)
    accept && is_time && trunc_val != comm_wr.data);
  c_reject: cover property (@(posedge mclk) disable iff (!rst_n)
    comm_wr_en && !in_range);
  c_kp_clash: cover property (@(posedge mclk) disable iff (!rst_n)
    accept && kp_wr_en && kp_wr.sel == comm_wr.sel);
  c_kp_read: cover property (@(posedge mclk) disable iff (!rst_n)
    kp_wr_en ##1 comm_rd_en);

endmodule
`default_nettype wire

// ---- testbench/drtp_host.sv ----
// Host controller model that issues link writes and reads.
`timescale 1ns/10ps
`default_nettype none
module drtp_host (
  // Clock
  input  wire logic                 mclk,
  // Link write port
  output logic                      comm_wr_en,
  output drtp_pkg::drtp_req_t       comm_wr,
  input  wire drtp_pkg::drtp_resp_t comm_wr_resp,
  // Link read port
  output logic                      comm_rd_en,
  output drtp_pkg::drtp_sel_t       comm_rd_sel,
  input  wire logic                 comm_rd_valid,
  input  wire logic [15:0]          comm_rd_data
);
  import drtp_pkg::*;

  // ==========================================================
  // Idle link at time zero.
  initial begin
    comm_wr_en = 1'b0;
    comm_wr = '0;
    comm_rd_en = 1'b0;
    comm_rd_sel = DRTP_SEL_ACCEL;
  end

  // One write; the data lines show the inverse once released.
  task automatic wr(input logic [17:0] w, output drtp_resp_t r);
    @(posedge mclk);
    #1;
    comm_wr_en = 1'b1;
    comm_wr = w;
    @(posedge mclk);
    #1;
    comm_wr_en = 1'b0;
    comm_wr.data = ~w[15:0];
    r = comm_wr_resp;
  endtask

  // One read; the answer is taken one cycle after the request.
  task automatic rd(input drtp_sel_t s, output logic [15:0] d, output logic v);
    @(posedge mclk);
    #1;
    comm_rd_en = 1'b1;
    comm_rd_sel = s;
    @(posedge mclk);
    #1;
    comm_rd_en = 1'b0;
    comm_rd_sel = drtp_sel_t'(~s);
    v = comm_rd_valid;
    d = comm_rd_data;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_drive_ramp_torque_param_regs.sv ----
// Self-checking bench for the ramp time and torque limit registers.
`timescale 1ns/10ps
`default_nettype none
`include "drtp_defs.svh"
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_drive_ramp_torque_param_regs;
  import drtp_pkg::*;
  logic        mclk, rst_n, kp_wr_en, comm_wr_en, comm_rd_en, comm_rd_valid;
  drtp_req_t   comm_wr, kp_wr;
  drtp_resp_t  comm_wr_resp, r;
  drtp_sel_t   comm_rd_sel;
  logic [15:0] comm_rd_data, acc, dec, dtq, btq, d;
  logic [15:0] exp_v [4];
  logic        v;
  int          error_cnt, n_tests, cycles;
  // Writes as {sel, data}: boundaries, refusals and truncation cases.
  localparam logic [17:0] WTAB [15] = '{
    18'h00000, 18'h08CA0, 18'h08CA1, 18'h004D2, 18'h103E7, 18'h103E8, 18'h1FFFF,
    18'h207D0, 18'h207CF, 18'h23A98, 18'h23A99, 18'h203E6, 18'h303E7, 18'h303E8,
    18'h30000};

  drtp_regs dut_u (.mclk(mclk), .rst_n(rst_n), .comm_wr_en(comm_wr_en),
    .comm_wr(comm_wr), .comm_wr_resp(comm_wr_resp), .comm_rd_en(comm_rd_en),
    .comm_rd_sel(comm_rd_sel), .comm_rd_valid(comm_rd_valid),
    .comm_rd_data(comm_rd_data), .kp_wr_en(kp_wr_en), .kp_wr(kp_wr),
    .internal_accel_time_1(acc), .internal_decel_time_1(dec),
    .internal_drive_torque_limit(dtq), .internal_brake_torque_limit(btq));
  drtp_host host_u (.mclk(mclk), .comm_wr_en(comm_wr_en), .comm_wr(comm_wr),
    .comm_wr_resp(comm_wr_resp), .comm_rd_en(comm_rd_en), .comm_rd_sel(comm_rd_sel),
    .comm_rd_valid(comm_rd_valid), .comm_rd_data(comm_rd_data));

  // Clock generation.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Legal ranges: ramp times 0..36000, limits 2000..15000 or 999.
  function automatic logic in_range(logic [17:0] w);
    if (w[17] == 1'b0) return w[15:0] <= `DRTP_TIME_MAX;
    return (w[15:0] >= `DRTP_TQ_MIN && w[15:0] <= `DRTP_TQ_MAX) ||
      w[15:0] == `DRTP_TQ_SPECIAL;
  endfunction

  // Setting output that belongs to a register.
  function automatic logic [15:0] setting(drtp_sel_t s);
    case (s)
      DRTP_SEL_ACCEL: return acc;
      DRTP_SEL_DECEL: return dec;
      DRTP_SEL_DRIVE_TQ: return dtq;
      default: return btq;
    endcase
  endfunction

  // Compare a setting and its link read against the expectation.
  task automatic chk_reg(input drtp_sel_t s);
    `CHK(setting(s), exp_v[s])
    host_u.rd(s, d, v);
    `CHK(v, 1'b1)
    `CHK(d, exp_v[s])
  endtask

  // Keypad edit, read back over the link in the very next cycle.
  task automatic kp_edit(input drtp_sel_t s, input logic [15:0] val);
    @(posedge mclk);
    #1;
    kp_wr_en = 1'b1;
    kp_wr = {s, val};
    exp_v[s] = val;
    fork
      host_u.rd(s, d, v);
      begin
        @(posedge mclk);
        #1;
        kp_wr_en = 1'b0;
      end
    join
    `CHK(v, 1'b1)
    `CHK(d, val)
    `CHK(setting(s), val)
  endtask

  // Verdict and end of run.
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cut a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Main sequence.
  initial begin
    error_cnt = 0;
    n_tests = 0;
    cycles = 0;
    rst_n = 1'b0;
    kp_wr_en = 1'b0;
    kp_wr = '0;
    exp_v = '{`DRTP_RST_ACCEL, `DRTP_RST_DECEL, `DRTP_RST_DRIVE_TQ, `DRTP_RST_BRAKE_TQ};
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) chk_reg(drtp_sel_t'(i));
    // Link writes, accepted and refused, each read back.
    foreach (WTAB[i]) begin
      host_u.wr(WTAB[i], r);
      `CHK(r, drtp_resp_t'({in_range(WTAB[i]), !in_range(WTAB[i])}))
      if (in_range(WTAB[i])) begin
        exp_v[WTAB[i][17:16]] = (WTAB[i][17] == 1'b0 && WTAB[i][15:0] >= `DRTP_TRUNC_MIN) ?
          WTAB[i][15:0] - WTAB[i][15:0] % `DRTP_TRUNC_STEP : WTAB[i][15:0];
      end
      chk_reg(drtp_sel_t'(WTAB[i][17:16]));
    end
    // Keypad edits, unchecked, show up in a link read issued the next cycle.
    for (int i = 0; i < 4; i++) kp_edit(drtp_sel_t'(i), 16'h4321 + 16'(i));
    // Link and keypad hit one register together: keypad wins, link is acknowledged.
    exp_v[DRTP_SEL_BRAKE_TQ] = 16'h1388;
    fork
      host_u.wr({DRTP_SEL_BRAKE_TQ, 16'h2710}, r);
      begin
        @(posedge mclk);
        #1;
        kp_wr_en = 1'b1;
        kp_wr = {DRTP_SEL_BRAKE_TQ, 16'h1388};
        @(posedge mclk);
        #1;
        kp_wr_en = 1'b0;
      end
    join
    `CHK(r, drtp_resp_t'(2'b10))
    chk_reg(DRTP_SEL_BRAKE_TQ);
    // Reset in mid-run returns settings and answers to their reset values.
    @(posedge mclk);
    #1;
    rst_n = 1'b0;
    @(posedge mclk);
    #1;
    `CHK(comm_wr_resp, drtp_resp_t'(2'b00))
    `CHK(comm_rd_valid, 1'b0)
    `CHK(comm_rd_data, 16'h0000)
    rst_n = 1'b1;
    exp_v = '{`DRTP_RST_ACCEL, `DRTP_RST_DECEL, `DRTP_RST_DRIVE_TQ, `DRTP_RST_BRAKE_TQ};
    for (int i = 0; i < 4; i++) chk_reg(drtp_sel_t'(i));
    report_and_stop();
  end
endmodule
`default_nettype wire
